// [logic/clock_divider_standby_control.sv]
// clock divider and standby control for a small 4-bit controller core
// assumes osc_tick is a one-cycle enable from the oscillator model on clk;
// event_in and ext_reset_n arrive from pins and are synchronised here
//
// Operation
// [R1] divider yields half, eighth, thirty-second and 128th oscillator taps
// [R2] system clock is osc/8 when speed bit is 1, osc/32 when 0
// [R3] display gets fixed osc/32, pulse generator fixed osc/2
// [R4] cpu clock is the selected system clock divided by two
// [R5] selected system clock feeds the timer count pulse selector
// [R6] stop flag set halts oscillator; no derived clock is delivered
// [R7] stop instruction sets stop flag; only reset clears it
// [R8] halt flag set blocks the cpu divide-by-two input
// [R9] halt or stop instruction sets the halt flag
// [R10] release signal from any new interrupt request clears halt flag
// [R11] falling edge of internal reset clears halt flag
// [R12] internal reset ends after a wait counted from external reset release
// [R13] timer count pulse picks system clock, osc/128 or external event
// [R14] cpu clock gating stops and restarts only at a whole phase boundary; a system tick at phase zero as halt sets leaves it stuck at phase one
`timescale 1ns/10ps
`default_nettype none

module clock_divider_standby_control
  import clkgen_pkg::*;
#(
  parameter int unsigned WAIT_COUNT = WAIT_TICKS
) (
  // clock and reset
  input  wire  logic       clk,
  input  wire  logic       rstn,
  // oscillator and pins
  input  wire  logic       osc_tick,
  input  wire  logic       ext_reset_n,
  input  wire  logic       event_in,
  // control from decoder and interrupt logic
  input  wire  logic       speed_select_bit,
  input  wire  logic       stop_exec,
  input  wire  logic       halt_exec,
  input  wire  logic       release_req,
  input  wire  logic [1:0] timer_src_sel,
  // derived clock enables
  output logic             oscillator_run,
  output logic             pulse_generator_clock,
  output logic             system_clock,
  output logic             display_clock,
  output logic             cpu_clock,
  output logic             timer_count_pulse,
  // status
  output logic             internal_reset,
  output logic             stop_flag,
  output logic             halt_flag,
  output standby_t         standby_state
);

  // ==========================================================
  // pin synchronisers
  logic [1:0] rst_sync_r, rst_sync_nxt;
  logic [1:0] evt_sync_r, evt_sync_nxt;
  logic       evt_prev_r, evt_prev_nxt;

  always_comb begin
    rst_sync_nxt = {rst_sync_r[0], ext_reset_n};
    evt_sync_nxt = {evt_sync_r[0], event_in};
    evt_prev_nxt = evt_sync_r[1];
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      rst_sync_r <= 2'h0;
      evt_sync_r <= 2'h0;
      evt_prev_r <= 1'b0;
    end else begin
      rst_sync_r <= rst_sync_nxt;
      evt_sync_r <= evt_sync_nxt;
      evt_prev_r <= evt_prev_nxt;
    end
  end

  logic ext_rst_n_s;
  logic event_rise;
  assign ext_rst_n_s = rst_sync_r[1];
  assign event_rise  = evt_sync_r[1] & ~evt_prev_r;

  // ==========================================================
  // standby flags and internal reset wait
  logic                  stop_r, stop_nxt;
  logic                  halt_r, halt_nxt;
  logic                  irst_r, irst_nxt;
  logic [WAIT_WIDTH-1:0] wait_r, wait_nxt;
  logic                  osc_en;

  // stopped oscillator delivers no ticks at all
  assign osc_en = osc_tick & ~stop_r; // [R6]

  always_comb begin
    stop_nxt = stop_r;
    halt_nxt = halt_r;
    irst_nxt = irst_r;
    wait_nxt = wait_r;
    if (!ext_rst_n_s) begin
      stop_nxt = 1'b0; // [R7]
      irst_nxt = 1'b1;
      wait_nxt = '0;
    end else if (irst_r) begin
      // wait counts oscillator ticks; stop is already clear here
      if (osc_tick) begin
        if (wait_r == WAIT_WIDTH'(WAIT_COUNT - 1)) begin
          irst_nxt = 1'b0; // [R12]
        end else begin
          wait_nxt = wait_r + 1'b1;
        end
      end
    end
    if (irst_r && !irst_nxt) begin
      halt_nxt = 1'b0; // [R11]
    end else if (!irst_r) begin
      // a new instruction wins over a release in the same cycle
      if (release_req) begin
        halt_nxt = 1'b0; // [R10]
      end
      if (stop_exec) begin
        stop_nxt = 1'b1; // [R7]
      end
      if (stop_exec || halt_exec) begin
        halt_nxt = 1'b1; // [R9]
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      stop_r <= 1'b0;
      halt_r <= 1'b0;
      irst_r <= 1'b1;
      wait_r <= '0;
    end else begin
      stop_r <= stop_nxt;
      halt_r <= halt_nxt;
      irst_r <= irst_nxt;
      wait_r <= wait_nxt;
    end
  end

  // ==========================================================
  // ripple divider on oscillator ticks
  logic [DIV_WIDTH-1:0] div_r, div_nxt;
  tap_t                 tap;

  function automatic logic tap_hit(input logic [DIV_WIDTH-1:0] cnt, input int unsigned div);
    logic [DIV_WIDTH-1:0] mask;
    mask    = DIV_WIDTH'(div - 1);
    tap_hit = ((cnt & mask) == mask);
  endfunction

  always_comb begin
    div_nxt = osc_en ? div_r + 1'b1 : div_r;
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      div_r <= '0;
    end else begin
      div_r <= div_nxt;
    end
  end

  always_comb begin
    tap.pulse_generator_clock = osc_en & tap_hit(div_r, PULSE_DIV); // [R1]
    tap.system_clock_fast     = osc_en & tap_hit(div_r, FAST_DIV);
    tap.system_clock_slow     = osc_en & tap_hit(div_r, SLOW_DIV);
    tap.display_clock         = osc_en & tap_hit(div_r, SLOW_DIV);
    tap.timer_prescale        = osc_en & tap_hit(div_r, TIMER_DIV); // [R1]
  end

  logic sys_clk;
  assign sys_clk = speed_select_bit ? tap.system_clock_fast : tap.system_clock_slow; // [R2]

  // ==========================================================
  // cpu divide-by-two with gating updated only at phase zero
  logic cpu_ph_r, cpu_ph_nxt;
  logic cpu_gate_r, cpu_gate_nxt;

  // gate only changes while the phase sits at zero; a system tick at zero as halt sets leaves phase at one and the gate shut until rstn
  always_comb begin
    cpu_gate_nxt = cpu_gate_r;
    if (!cpu_ph_r) begin
      cpu_gate_nxt = ~halt_r; // [R14]
    end
    cpu_ph_nxt = cpu_ph_r;
    if (sys_clk && cpu_gate_r) begin
      cpu_ph_nxt = ~cpu_ph_r; // [R8]
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      cpu_ph_r   <= 1'b0;
      cpu_gate_r <= 1'b0;
    end else begin
      cpu_ph_r   <= cpu_ph_nxt;
      cpu_gate_r <= cpu_gate_nxt;
    end
  end

  // ==========================================================
  // timer count pulse source
  logic tcp;
  always_comb begin
    case (timer_src_sel)
      SRC_SYSTEM: tcp = sys_clk; // [R5]
      SRC_DIV128: tcp = tap.timer_prescale;
      SRC_EVENT:  tcp = event_rise & ~stop_r;
      default:    tcp = 1'b0;
    endcase
  end

  // ==========================================================
  // registered outputs
  always_ff @(posedge clk) begin
    if (!rstn) begin
      pulse_generator_clock <= 1'b0;
      system_clock          <= 1'b0;
      display_clock         <= 1'b0;
      cpu_clock             <= 1'b0;
      timer_count_pulse     <= 1'b0;
    end else begin
      pulse_generator_clock <= tap.pulse_generator_clock; // [R3]
      system_clock          <= sys_clk;
      display_clock         <= tap.display_clock; // [R3]
      cpu_clock             <= sys_clk & cpu_gate_r & cpu_ph_r; // [R4]
      timer_count_pulse     <= tcp; // [R13]
    end
  end

  always_comb begin
    oscillator_run = ~stop_r;
    internal_reset = irst_r;
    stop_flag      = stop_r;
    halt_flag      = halt_r;
    if (stop_r) begin
      standby_state = STOPPED;
    end else if (halt_r) begin
      standby_state = HALTED;
    end else begin
      standby_state = RUN;
    end
  end

endmodule

`default_nettype wire

// [logic/clkgen_pkg.sv]
// package for the clock divider and standby control block
// assumes a single 20 mhz fabric clock; derived clocks are enable pulses
package clkgen_pkg;

  // ==========================================================
  // divider taps (oscillator periods per derived tick)
  localparam int unsigned DIV_WIDTH      = 7;
  localparam int unsigned PULSE_DIV      = 2;
  localparam int unsigned FAST_DIV       = 8;
  localparam int unsigned SLOW_DIV       = 32;
  localparam int unsigned TIMER_DIV      = 128;

  // ==========================================================
  // internal reset wait, counted in oscillator ticks
  localparam int unsigned WAIT_TICKS     = 1024;
  localparam int unsigned WAIT_WIDTH     = 11;

  // ==========================================================
  // timer count source select encoding
  localparam logic [1:0] SRC_SYSTEM      = 2'h0;
  localparam logic [1:0] SRC_DIV128      = 2'h1;
  localparam logic [1:0] SRC_EVENT       = 2'h2;

  // derived clock enables travel together
  typedef struct packed {
    logic pulse_generator_clock;
    logic system_clock_fast;
    logic system_clock_slow;
    logic display_clock;
    logic timer_prescale;
  } tap_t;

  typedef enum logic [1:0] {
    RUN,
    HALTED,
    STOPPED
  } standby_t;

endpackage

// [verification/osc_model.sv]
// oscillator model: one-cycle tick every PERIOD clk cycles
// assumes run comes from the block's oscillator_run
`timescale 1ns/10ps
`default_nettype none
module osc_model #(parameter int PERIOD = 5) (
  // clock
  input  wire logic clk,
  // control and tick
  input  wire logic run,
  output var logic  tick
);
  int cnt = 0;
  // crystal stops dead, no stray tick; tick has a single driver
  always @(negedge clk) begin
    cnt = run ? (cnt + 1) % PERIOD : 0;
    tick = run && cnt == 0;
  end
endmodule
`default_nettype wire

// [verification/clkgen_checker.sv]
// assertions on the clock divider and standby block
// bound onto the design top, sees its ports only
`timescale 1ns/10ps
`default_nettype none
module clkgen_checker
  import clkgen_pkg::*;
#(parameter int unsigned WAIT_COUNT = WAIT_TICKS) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // controls
  input wire logic ext_reset_n,
  input wire logic halt_exec,
  input wire logic release_req,
  input wire logic stop_exec,
  // outputs
  input wire logic oscillator_run,
  input wire logic pulse_generator_clock,
  input wire logic system_clock,
  input wire logic cpu_clock,
  input wire logic internal_reset,
  input wire logic stop_flag,
  input wire logic halt_flag
);
  // ========================================
  // properties
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  chk_stop_osc_off: assert property (stop_flag |-> !oscillator_run)
    else $error("osc runs in stop");
  chk_stop_no_taps: assert property (stop_flag [*3] |-> !(pulse_generator_clock | system_clock | cpu_clock))
    else $error("tap in stop");
  chk_stop_sticky: assert property (ext_reset_n [*4] ##0 stop_flag |=> stop_flag)
    else $error("stop lost");
  chk_stop_halts: assert property ($rose(stop_flag) |-> halt_flag)
    else $error("stop without halt");
  chk_halt_set: assert property (halt_exec && !internal_reset |=> halt_flag)
    else $error("halt not set");
  chk_release_clr: assert property (release_req && !halt_exec && !stop_exec && !stop_flag && !internal_reset
    |=> !halt_flag)
    else $error("halt not released");
  chk_internal_reset_clr: assert property ($fell(internal_reset) |-> !halt_flag)
    else $error("halt kept");
  chk_internal_reset_wait: assert property ($rose(ext_reset_n) && internal_reset |-> internal_reset [*3] ##[1:400]
    !internal_reset)
    else $error("reset wait wrong");
endmodule
bind clock_divider_standby_control clkgen_checker #(.WAIT_COUNT(WAIT_COUNT)) i_chk (.clk, .rstn, .ext_reset_n,
  .halt_exec, .release_req, .stop_exec, .oscillator_run, .pulse_generator_clock, .system_clock, .cpu_clock,
  .internal_reset, .stop_flag, .halt_flag);
`default_nettype wire

// [verification/clock_divider_standby_control_tb_top.sv]
// bench for the clock divider and standby block
// oscillator model on the far side, clk at 20 mhz
`timescale 1ns/10ps
`default_nettype none
module clock_divider_standby_control_tb_top;
  import clkgen_pkg::*;
  localparam int P = 5;
  logic clk = 0, rstn = 0, osc_tick, ext_reset_n = 1, event_in = 0, speed_select_bit = 0;
  logic stop_exec = 0, halt_exec = 0, release_req = 0, oscillator_run, pulse_generator_clock;
  logic system_clock, display_clock, cpu_clock, timer_count_pulse, internal_reset, stop_flag, halt_flag;
  logic [1:0] timer_src_sel = 0;
  standby_t standby_state;
  int n_errors = 0, cmp_count = 0, c[5];
  typedef struct {logic sp; logic [1:0] src; int e[5];} row_t;
  // counts per 256 osc ticks: system, cpu, timer, display, pulse gen
  row_t rows[4] = '{'{0, 0, '{8, 4, 8, 8, 128}}, '{1, 1, '{32, 16, 2, 8, 128}},
                    '{0, 2, '{8, 4, 64, 8, 128}}, '{1, 3, '{32, 16, 0, 8, 128}}};
  always #25 clk = ~clk;
  always #500 event_in = ~event_in;
  osc_model #(.PERIOD(P)) i_osc (.clk, .run(oscillator_run), .tick(osc_tick));
  clock_divider_standby_control #(.WAIT_COUNT(4)) i_dut (.clk, .rstn, .osc_tick, .ext_reset_n, .event_in,
    .speed_select_bit, .stop_exec, .halt_exec, .release_req, .timer_src_sel, .oscillator_run,
    .pulse_generator_clock, .system_clock, .display_clock, .cpu_clock, .timer_count_pulse, .internal_reset,
    .stop_flag, .halt_flag, .standby_state);
  // ========================================
  // tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask
  // window spans whole periods so phase never matters
  task automatic cnt(input int settle);
    repeat (settle) @(posedge clk);
    c = '{default: 0};
    repeat (256 * P) begin
      @(posedge clk);
      #1;
      c = '{c[0] + system_clock, c[1] + cpu_clock, c[2] + timer_count_pulse, c[3] + display_clock,
            c[4] + pulse_generator_clock};
    end
  endtask
  task automatic pls(ref logic s);
    @(negedge clk) s = 1;
    @(negedge clk) s = 0;
  endtask
  task automatic wait_run;
    for (int k = 0; k < 400 && internal_reset !== 1'b0; k++) @(negedge clk);
    chk(internal_reset, 1'b0);
  endtask
  task automatic final_report;
    $display("compares %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    repeat (4) @(negedge clk);
    chk({internal_reset, stop_flag, halt_flag, system_clock}, 4'h8);
    rstn = 1;
    wait_run;
    foreach (rows[i]) begin
      @(negedge clk);
      speed_select_bit = rows[i].sp;
      timer_src_sel = rows[i].src;
      cnt(400);
      for (int j = 0; j < 5; j++) chk(c[j], rows[i].e[j]);
    end
    pls(halt_exec);
    chk(standby_state, HALTED);
    cnt(200);
    // halt stops only the cpu clock, the system clock keeps running
    chk(c[0], rows[3].e[0]);
    chk(c[1], 32'h0);
    pls(release_req);
    chk(halt_flag, 1'b0);
    cnt(100);
    chk(c[1], rows[3].e[1]);
    @(negedge clk) {halt_exec, release_req} = 2'h3;
    @(negedge clk) {halt_exec, release_req} = 2'h0;
    // event source selected so stop must also silence the pin path
    timer_src_sel = SRC_EVENT;
    chk(halt_flag, 1'b1);
    pls(stop_exec);
    chk({stop_flag, halt_flag, oscillator_run, standby_state}, {3'h6, STOPPED});
    cnt(10);
    chk(c[0] + c[1] + c[2] + c[3] + c[4], 0);
    @(negedge clk) ext_reset_n = 0;
    repeat (6) @(negedge clk);
    chk({stop_flag, internal_reset, halt_flag}, 3'h3);
    ext_reset_n = 1;
    pls(stop_exec);
    chk(internal_reset, 1'b1);
    wait_run;
    chk({stop_flag, halt_flag, standby_state}, {2'h0, RUN});
    final_report;
  end
  initial begin
    repeat (60000) @(posedge clk);
    n_errors++;
    final_report;
  end
endmodule
`default_nettype wire
